// ===== hw/pcs_pin_mux.sv
// Pin mux for three parallel-port control pins: GPIO or memory chip selects
//
// Operation
// RL1 - Strap low in reset gives GPIO; strap high gives chip select.
// RL2 - Strap-chosen function takes effect when reset is released.
// RL3 - GPIO pins come out of reset as inputs.
// RL4 - Chip-select pins float in reset, then drive inactive high.
// RL5 - Pins a, b, c carry chip selects 0, 1, 2 in memory mode.
// RL6 - All three pins float while reset is held.
// RL7 - Pins float while the hold request is active.
// RL8 - In hold, each memory clock toggles or floats per its float bit.
// RL9 - Pins float in off mode: test reset 0, emulation a 1, off pin 0.
// RL10 - Bus holder enabled after reset, switchable by software.
// RL11 - GPIO pins are software-configurable as input or output.
// RL12 - Selected function stays fixed until the next reset release; the code returns it to GPIO while reset is held.
`timescale 1ns/1ps

module pcs_pin_mux (
    input  wire logic       mclk,                // 100 MHz clock
    input  wire logic       sys_rst,             // Sync reset, high
    input  wire logic       boot_function_strap, // Strap pin
    input  wire logic       hold_req_n,          // Hold request pin, low
    input  wire logic       test_rst_n,          // Test reset pin, low
    input  wire logic       emulation_pin_a,     // Emulation pin a
    input  wire logic       emulation_off_pin,   // Emulation/off pin

    input  wire logic       ctrl_pin_a_in,       // Pin a level
    output logic            ctrl_pin_a_out,      // Pin a drive value
    output logic            ctrl_pin_a_oe,       // Pin a drive enable
    input  wire logic       ctrl_pin_b_in,       // Pin b level
    output logic            ctrl_pin_b_out,      // Pin b drive value
    output logic            ctrl_pin_b_oe,       // Pin b drive enable
    input  wire logic       ctrl_pin_c_in,       // Pin c level
    output logic            ctrl_pin_c_out,      // Pin c drive value
    output logic            ctrl_pin_c_oe,       // Pin c drive enable

    input  wire logic       gp_dir_wr,           // Direction write strobe
    input  wire logic [2:0] gp_dir_wdata,        // 1 = output
    input  wire logic       gp_out_wr,           // Output write strobe
    input  wire logic [2:0] gp_out_wdata,        // Output levels
    output logic      [2:0] par_gp_io_in,        // Pin levels read back
    output logic      [2:0] par_gp_io_dir,       // Direction read back

    input  wire logic [2:0] mem_chip_select_req, // Select asserted, high
    input  wire logic       holder_wr,           // Bus holder write strobe
    input  wire logic       holder_wdata,        // Bus holder enable value
    output logic            bus_holder_en,       // Bus holder enable

    input  wire logic [1:0] mem_clk_src,         // Memory clock sources
    input  wire logic [1:0] mem_clk_hold_float,  // Float clock in hold
    output logic      [1:0] mem_clock_out,       // Memory clock values
    output logic      [1:0] mem_clock_out_oe,    // Memory clock enables

    output logic            fn_chip_select,      // Function is chip select
    output logic            pins_floating        // Pins held floating
);

    // ********************************
    // Synchronisers
    // ********************************

    logic [pcs_pkg::SYNC_W-1:0] sync_raw;
    logic [pcs_pkg::SYNC_W-1:0] sync1_q;
    logic [pcs_pkg::SYNC_W-1:0] sync2_q;

    assign sync_raw = {ctrl_pin_c_in,
                       ctrl_pin_b_in,
                       ctrl_pin_a_in,
                       emulation_off_pin,
                       emulation_pin_a,
                       test_rst_n,
                       hold_req_n,
                       boot_function_strap};

    always_ff @(posedge mclk) begin
        sync1_q <= sync_raw;
        sync2_q <= sync1_q;
    end

    // ********************************
    // Mode decode
    // ********************************

    logic             hold_act;
    logic             off_act;
    logic [2:0]       pin_in_s;
    pcs_pkg::pcs_mode_t mode_d;

    assign hold_act = ~sync2_q[pcs_pkg::SYNC_HOLD];
    assign off_act  = ~sync2_q[pcs_pkg::SYNC_TRST]
                    &  sync2_q[pcs_pkg::SYNC_EMU_A]
                    & ~sync2_q[pcs_pkg::SYNC_EMU_O]; // RL9
    assign pin_in_s = sync2_q[pcs_pkg::SYNC_PIN +: 3];

    always_comb begin
        if (sys_rst) begin
            mode_d = pcs_pkg::PCS_MD_RST; // RL6
        end else if (off_act) begin
            mode_d = pcs_pkg::PCS_MD_OFF; // RL9
        end else if (hold_act) begin
            mode_d = pcs_pkg::PCS_MD_HOLD; // RL7
        end else begin
            mode_d = pcs_pkg::PCS_MD_RUN;
        end
    end

    // ********************************
    // Strap capture
    // ********************************

    logic            strap_q;
    logic            rst_prev_q;
    pcs_pkg::pcs_fn_t fn_q;

    // Strap sampled while reset is held
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strap_q <= sync2_q[pcs_pkg::SYNC_STRAP]; // RL1
        end
    end

    always_ff @(posedge mclk) begin
        rst_prev_q <= sys_rst;
    end

    // Function latched only on the release edge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fn_q <= pcs_pkg::PCS_FN_GPIO;
        end else if (rst_prev_q) begin
            fn_q <= pcs_pkg::pcs_fn_t'(strap_q); // RL2 RL12
        end
    end

    // ********************************
    // Software control bits
    // ********************************

    logic [2:0] gp_dir_q;
    logic [2:0] gp_out_q;
    logic       holder_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gp_dir_q <= pcs_pkg::GP_DIR_RST; // RL3
        end else if (gp_dir_wr) begin
            gp_dir_q <= gp_dir_wdata; // RL11
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gp_out_q <= pcs_pkg::GP_OUT_RST;
        end else if (gp_out_wr) begin
            gp_out_q <= gp_out_wdata; // RL11
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            holder_q <= pcs_pkg::HOLDER_RST; // RL10
        end else if (holder_wr) begin
            holder_q <= holder_wdata; // RL10
        end
    end

    // ********************************
    // Pin drive
    // ********************************

    // Returns {enable, value} for one pin
    function automatic logic [1:0] pin_drive(
        input pcs_pkg::pcs_mode_t mode,
        input pcs_pkg::pcs_fn_t   fn,
        input logic               dir,
        input logic               dout,
        input logic               cs_req
    );
        logic [1:0] res;
        res = {1'b0, pcs_pkg::CS_IDLE};
        if (mode != pcs_pkg::PCS_MD_RUN) begin
            res = {1'b0, pcs_pkg::CS_IDLE}; // RL6 RL7 RL9
        end else if (fn == pcs_pkg::PCS_FN_CS) begin
            res = {1'b1, ~cs_req}; // RL4
        end else begin
            res = {dir, dout}; // RL3 RL11
        end
        return res;
    endfunction

    logic [2:0] pin_out_q;
    logic [2:0] pin_oe_q;

    genvar gi;
    generate
        for (gi = 0; gi < pcs_pkg::NUM_PINS; gi++) begin : g_pin
            logic [1:0] drv;
            // Bit gi carries chip select gi
            assign drv = pin_drive(mode_d,
                                   fn_q,
                                   gp_dir_q[gi],
                                   gp_out_q[gi],
                                   mem_chip_select_req[gi]); // RL5

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    pin_oe_q[gi]  <= pcs_pkg::PIN_OE_RST[gi]; // RL6
                    pin_out_q[gi] <= pcs_pkg::PIN_OUT_RST[gi];
                end else begin
                    pin_oe_q[gi]  <= drv[1];
                    pin_out_q[gi] <= drv[0];
                end
            end
        end
    endgenerate

    assign ctrl_pin_a_out = pin_out_q[0];
    assign ctrl_pin_a_oe  = pin_oe_q[0];
    assign ctrl_pin_b_out = pin_out_q[1];
    assign ctrl_pin_b_oe  = pin_oe_q[1];
    assign ctrl_pin_c_out = pin_out_q[2];
    assign ctrl_pin_c_oe  = pin_oe_q[2];

    // ********************************
    // Memory clock outputs
    // ********************************

    logic [1:0] clk_out_q;
    logic [1:0] clk_oe_q;
    logic [1:0] clk_oe_d;

    always_comb begin
        case (mode_d)
            pcs_pkg::PCS_MD_RUN:  clk_oe_d = 2'h3;
            pcs_pkg::PCS_MD_HOLD: clk_oe_d = ~mem_clk_hold_float; // RL8
            default:              clk_oe_d = 2'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clk_out_q <= pcs_pkg::CLK_OUT_RST;
            clk_oe_q  <= pcs_pkg::CLK_OE_RST;
        end else begin
            clk_out_q <= mem_clk_src; // RL8
            clk_oe_q  <= clk_oe_d;
        end
    end

    assign mem_clock_out    = clk_out_q;
    assign mem_clock_out_oe = clk_oe_q;

    // ********************************
    // Status outputs
    // ********************************

    logic [2:0] gp_in_q;
    logic       float_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gp_in_q <= pcs_pkg::GP_IN_RST;
            float_q <= 1'b1;
        end else begin
            gp_in_q <= pin_in_s;
            float_q <= (mode_d != pcs_pkg::PCS_MD_RUN);
        end
    end

    assign par_gp_io_in   = gp_in_q;
    assign par_gp_io_dir  = gp_dir_q;
    assign bus_holder_en  = holder_q;
    assign fn_chip_select = fn_q;
    assign pins_floating  = float_q;

endmodule

// ===== hw/pcs_pkg.sv
// Constants and types for the parallel-port chip-select pin mux
package pcs_pkg;

    localparam int NUM_PINS = 3;
    localparam int NUM_CLKS = 2;

    // Synchroniser vector layout
    localparam int SYNC_W     = 8;
    localparam int SYNC_STRAP = 0;
    localparam int SYNC_HOLD  = 1;
    localparam int SYNC_TRST  = 2;
    localparam int SYNC_EMU_A = 3;
    localparam int SYNC_EMU_O = 4;
    localparam int SYNC_PIN   = 5;

    // Values after reset
    localparam logic [2:0] GP_DIR_RST  = 3'h0;
    localparam logic [2:0] GP_OUT_RST  = 3'h0;
    localparam logic [2:0] GP_IN_RST   = 3'h0;
    localparam logic [2:0] PIN_OUT_RST = 3'h7;
    localparam logic [2:0] PIN_OE_RST  = 3'h0;
    localparam logic [1:0] CLK_OUT_RST = 2'h0;
    localparam logic [1:0] CLK_OE_RST  = 2'h0;
    localparam logic       HOLDER_RST  = 1'h1;
    localparam logic       CS_IDLE     = 1'h1;

    typedef enum logic [0:0] {
        PCS_FN_GPIO = 1'b0,
        PCS_FN_CS   = 1'b1
    } pcs_fn_t;

    typedef enum logic [1:0] {
        PCS_MD_RUN  = 2'b00,
        PCS_MD_RST  = 2'b01,
        PCS_MD_HOLD = 2'b10,
        PCS_MD_OFF  = 2'b11
    } pcs_mode_t;

endpackage

// ===== dv/pcs_pin_mux_properties.sv
// Checker of pin mux drive and float rules
`timescale 1ns/1ps
module pcs_pin_mux_chk (
    input wire logic       mclk,               // Clock
    input wire logic       sys_rst,            // Reset
    input wire logic       hold_req_n,         // Hold
    input wire logic       test_rst_n,         // Test reset
    input wire logic       emulation_pin_a,    // Emu a
    input wire logic       emulation_off_pin,  // Off pin
    input wire logic       ctrl_pin_a_oe,      // Pin a en
    input wire logic       ctrl_pin_b_oe,      // Pin b en
    input wire logic       ctrl_pin_c_oe,      // Pin c en
    input wire logic [2:0] par_gp_io_dir,      // Direction
    input wire logic [1:0] mem_clk_hold_float, // Float bits
    input wire logic [1:0] mem_clock_out_oe,   // Clock en
    input wire logic       bus_holder_en,      // Holder
    input wire logic       fn_chip_select,     // Function
    input wire logic       pins_floating       // Floating
);
    logic [2:0] oe;
    assign oe = {ctrl_pin_c_oe, ctrl_pin_b_oe, ctrl_pin_a_oe};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence hold_seq;
        (!hold_req_n && test_rst_n)[*4];
    endsequence
    sequence off_seq;
        (!test_rst_n && emulation_pin_a && !emulation_off_pin)[*4];
    endsequence
    sequence run_seq;
        (hold_req_n && test_rst_n)[*4];
    endsequence
    rst_release_a: assert property ($fell(sys_rst) |-> oe == 3'h0 && pins_floating && bus_holder_en)
        else $error("pins not floating at reset release");
    gp_dir_drive_a: assert property (!fn_chip_select && !pins_floating && !$past(pins_floating)
        |-> oe == $past(par_gp_io_dir)) else $error("gpio enable differs from direction");
    cs_drive_a: assert property (fn_chip_select && $past(fn_chip_select) && !pins_floating |-> oe == 3'h7)
        else $error("chip selects not driven");
    hold_float_a: assert property (hold_seq |-> pins_floating && oe == 3'h0)
        else $error("pins driven in hold");
    hold_clock_a: assert property (hold_seq |-> mem_clock_out_oe == ~$past(mem_clk_hold_float))
        else $error("clock enable wrong in hold");
    off_float_a: assert property (off_seq |-> pins_floating && oe == 3'h0)
        else $error("pins driven in off mode");
    run_drive_a: assert property (run_seq |-> !pins_floating && mem_clock_out_oe == 2'h3)
        else $error("pins floating in run mode");
    fn_fixed_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(fn_chip_select))
        else $error("function changed while running");
endmodule

bind pcs_pin_mux pcs_pin_mux_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .hold_req_n(hold_req_n),
    .test_rst_n(test_rst_n), .emulation_pin_a(emulation_pin_a), .emulation_off_pin(emulation_off_pin),
    .ctrl_pin_a_oe(ctrl_pin_a_oe), .ctrl_pin_b_oe(ctrl_pin_b_oe), .ctrl_pin_c_oe(ctrl_pin_c_oe),
    .par_gp_io_dir(par_gp_io_dir), .mem_clk_hold_float(mem_clk_hold_float),
    .mem_clock_out_oe(mem_clock_out_oe), .bus_holder_en(bus_holder_en),
    .fn_chip_select(fn_chip_select), .pins_floating(pins_floating));

// ===== dv/pcs_mem_model.sv
// Far side of the pins: memory devices and line resolution
`timescale 1ns/1ps
module pcs_mem_model (
    input  wire logic       mclk,    // Clock
    input  wire logic [2:0] pin_out, // Device value
    input  wire logic [2:0] pin_oe,  // Device enable
    input  wire logic [2:0] ext_oe,  // Far side enable
    input  wire logic [2:0] ext_val, // Far side value
    output logic      [2:0] pin_lvl  // Line level
);
    logic [2:0] noise_q = 3'h5;
    // No pull on these lines, so a released line wanders
    always @(posedge mclk) noise_q <= ~noise_q;
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe & noise_q);
endmodule

// ===== dv/parallel_port_chip_select_pin_mux_test.sv
// Testbench of the chip-select pin mux
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module parallel_port_chip_select_pin_mux_test;
    logic       mclk = 1'b0;
    logic       rst, strap, hold_n, trst_n, emu_a, emu_off, dir_wr, out_wr, h_wr, h_wd, holder, fn, flt;
    logic [2:0] dir_wd, out_wd, req, ext_oe, ext_val, lvl, pout, poe, gin, gdir;
    logic [1:0] csrc = 2'h1;
    logic [1:0] cflt, cout, coe;
    int         mismatches, samples_checked, cycles, seed, i;
    pcs_pin_mux dut (.mclk(mclk), .sys_rst(rst), .boot_function_strap(strap), .hold_req_n(hold_n),
        .test_rst_n(trst_n), .emulation_pin_a(emu_a), .emulation_off_pin(emu_off),
        .ctrl_pin_a_in(lvl[0]), .ctrl_pin_a_out(pout[0]), .ctrl_pin_a_oe(poe[0]),
        .ctrl_pin_b_in(lvl[1]), .ctrl_pin_b_out(pout[1]), .ctrl_pin_b_oe(poe[1]),
        .ctrl_pin_c_in(lvl[2]), .ctrl_pin_c_out(pout[2]), .ctrl_pin_c_oe(poe[2]),
        .gp_dir_wr(dir_wr), .gp_dir_wdata(dir_wd), .gp_out_wr(out_wr), .gp_out_wdata(out_wd),
        .par_gp_io_in(gin), .par_gp_io_dir(gdir), .mem_chip_select_req(req), .holder_wr(h_wr),
        .holder_wdata(h_wd), .bus_holder_en(holder), .mem_clk_src(csrc), .mem_clk_hold_float(cflt),
        .mem_clock_out(cout), .mem_clock_out_oe(coe), .fn_chip_select(fn), .pins_floating(flt));
    pcs_mem_model far (.mclk(mclk), .pin_out(pout), .pin_oe(poe), .ext_oe(ext_oe), .ext_val(ext_val),
        .pin_lvl(lvl));
    always #5 mclk = ~mclk;
    always @(posedge mclk) csrc <= #1 ~csrc;
    function automatic logic [2:0] lvl_exp(input logic [2:0] d, v, e);
        return (d & v) | (~d & e);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, strap, hold_n, trst_n, emu_a, emu_off, dir_wr, out_wr, h_wr, h_wd} = 10'h2F1;
        {dir_wd, out_wd, req, ext_oe, ext_val, cflt} = 17'h0;
        seed = 26582;
        tick(8);
        `CHK("oe", 3'h0, poe);
        rst = 1'b0;
        tick(3);
        `CHK("fn", 1'b0, fn);
        `CHK("oe", 3'h0, poe);
        `CHK("dir", 3'h0, gdir);
        for (i = 0; i < 16; i++) begin
            dir_wd = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($random(seed));
            out_wd = 3'($random(seed));
            ext_val = 3'($random(seed));
            ext_oe = ~dir_wd;
            dir_wr = 1'b1;
            tick(1);
            dir_wr = 1'b0;
            out_wr = 1'b1;
            tick(1);
            out_wr = 1'b0;
            tick(5);
            `CHK("oe", dir_wd, poe);
            `CHK("dir", dir_wd, gdir);
            `CHK("in", lvl_exp(dir_wd, out_wd, ext_val), gin);
        end
        for (i = 0; i < 2; i++) begin
            h_wd = 1'(i);
            h_wr = 1'b1;
            tick(1);
            h_wr = 1'b0;
            tick(1);
            `CHK("holder", 1'(i), holder);
        end
        // All pins driving, so hold and off must visibly release them
        dir_wd = 3'h7;
        dir_wr = 1'b1;
        tick(1);
        dir_wr = 1'b0;
        tick(2);
        for (i = 0; i < 4; i++) begin
            cflt = 2'(i);
            hold_n = 1'b0;
            tick(4);
            `CHK("hold oe", 3'h0, poe);
            `CHK("clk oe", ~cflt, coe);
            `CHK("clk out", csrc, cout);
            hold_n = 1'b1;
            tick(4);
        end
        {trst_n, emu_a, emu_off} = 3'h2;
        tick(4);
        `CHK("off oe", 3'h0, poe);
        emu_a = 1'b0;
        tick(4);
        `CHK("not off", 1'b0, flt);
        {trst_n, emu_off, ext_oe, rst, strap, h_wd, h_wr} = 9'h18D;
        tick(1);
        h_wr = 1'b0;
        tick(7);
        `CHK("holder", 1'b1, holder);
        `CHK("oe", 3'h0, poe);
        rst = 1'b0;
        tick(3);
        `CHK("fn", 1'b1, fn);
        `CHK("cs", 6'h3F, {poe, pout});
        for (i = 0; i < 9; i++) begin
            req = (i < 3) ? 3'h1 << i : 3'($random(seed));
            tick(2);
            `CHK("cs out", ~req, pout);
        end
        strap = 1'b0;
        dir_wd = 3'h0;
        dir_wr = 1'b1;
        tick(1);
        dir_wr = 1'b0;
        tick(5);
        `CHK("fn kept", 4'hF, {fn, poe});
        close_out();
    end
endmodule
